// ### verilog/uab_autobaud.v
// Purpose: auto-baud measurement unit and scratch byte of a UART, AHB-Lite slave
// Assumes: one clock, synchronous active-high reset, single word transfers
// Notes: writes finish with no wait; reads take one wait cycle
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uab_autobaud_regs.vh"

module uab_autobaud #(
	parameter CNT_WIDTH = 16
) (
	input wire clk,
	input wire reset,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire rxd,
	output reg [7:0] divisorLowByte,
	output reg [7:0] divisorHighByte,
	output reg rsrReset,
	output reg rsrBaudTick,
	output reg rsrFastRate,
	output reg completionEventFlag,
	output reg timeoutEventFlag
);
	// measurement states
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_WAIT = 2'b01;
	localparam [1:0] ST_MEAS = 2'b10;

	// bus phase capture
	reg wrPend_q; // write data phase in progress
	reg [31:0] wrAddr_q; // address of that write
	reg rdPend_q; // read data phase, first (wait) cycle
	reg [31:0] rdAddr_q; // address of that read
	wire accept; // address phase taken this edge

	// software-visible state
	reg [7:0] scratch_q; // free byte, drives nothing
	reg mode_q; // 1 = start bit only
	reg restart_q; // re-arm after overflow
	reg completionEnable_q; // gate for completion event
	reg timeoutEnable_q; // gate for timeout event

	// measurement machine
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [4:0] prescale_q; // divides clk by sixteen
	reg [4:0] ticksLeft_q; // baud ticks still owed
	reg loadDone_q; // latches were loaded last cycle
	wire rxFall;
	wire rxRise;
	wire [CNT_WIDTH-1:0] rateCount;
	wire rateOverflow;
	wire prescaleTick;
	wire stopEdge;
	wire [CNT_WIDTH-1:0] loadValue;
	wire [CNT_WIDTH-1:0] spanCount; // count with a tick that meets the stop edge
	wire [CNT_WIDTH+15:0] loadWide; // load value padded for the latches
	wire armNow; // run armed from idle this cycle

	// decoded write effects
	wire ctlWrite;
	wire startWrite;
	wire abortWrite;
	wire eoClear;
	wire toClear;

	// events of this cycle, from the machine
	reg enterMeas;
	reg measDone;
	reg measTimeout;

	// one function serves both read and write decode
	function hit;
		input [31:0] addr;
		input [31:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// read mux; reserved and unmapped bits read zero
	function [31:0] readWord;
		input [31:0] addr;
		begin
			readWord = 32'h00000000;
			if (hit(addr, `UAB_SCRATCH_ADDR)) begin
				readWord[7:0] = scratch_q;
			end
			if (hit(addr, `UAB_CONTROL_ADDR)) begin
				// start reads back as pending/finished
				readWord[`UAB_CTL_START] = (state_q != ST_IDLE);
				readWord[`UAB_CTL_MODE] = mode_q;
				readWord[`UAB_CTL_RESTART] = restart_q;
			end
			if (hit(addr, `UAB_DIVISOR_ADDR)) begin
				readWord[15:0] = {divisorHighByte, divisorLowByte};
			end
			if (hit(addr, `UAB_ENABLE_ADDR)) begin
				readWord[`UAB_EV_COMPLETION] = completionEnable_q;
				readWord[`UAB_EV_TIMEOUT] = timeoutEnable_q;
			end
			if (hit(addr, `UAB_FLAGS_ADDR)) begin
				readWord[`UAB_EV_COMPLETION] = completionEventFlag;
				readWord[`UAB_EV_TIMEOUT] = timeoutEventFlag;
			end
		end
	endfunction

	// receive pin synchroniser and edge finder
	uab_rx_sync rxSync (
		.clk(clk),
		.reset(reset),
		.rxd(rxd),
		.rxFall(rxFall),
		.rxRise(rxRise)
	);

	// bit-time counter, cleared as the start bit begins
	uab_rate_counter #(
		.WIDTH(CNT_WIDTH)
	) rateCounter (
		.clk(clk),
		.reset(reset),
		.clear(enterMeas | armNow),
		.tick(prescaleTick),
		.count(rateCount),
		.overflow(rateOverflow)
	);

	// address phase accepted: only non-sequential/sequential, selected
	assign accept = hsel & htrans[1] & hready;

	// bus slave: writes zero-wait, reads one wait cycle so data is fresh
	always @(posedge clk) begin
		if (reset) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 32'h00000000;
			rdPend_q <= 1'b0;
			rdAddr_q <= 32'h00000000;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0; // always OKAY
			wrPend_q <= accept & hwrite;
			rdPend_q <= accept & ~hwrite;
			if (accept) begin
				wrAddr_q <= haddr;
				rdAddr_q <= haddr;
			end
			if (accept && !hwrite) begin
				// wait one cycle; a preceding write lands meanwhile
				hreadyout <= 1'b0;
			end else if (rdPend_q) begin
				hrdata <= readWord(rdAddr_q);
				hreadyout <= 1'b1;
			end else begin
				hreadyout <= 1'b1;
			end
		end
	end

	// control register write effects
	assign ctlWrite = wrPend_q & hit(wrAddr_q, `UAB_CONTROL_ADDR);
	assign startWrite = ctlWrite & hwdata[`UAB_CTL_START];
	assign abortWrite = ctlWrite & ~hwdata[`UAB_CTL_START];
	assign eoClear = ctlWrite & hwdata[`UAB_CTL_EO_CLR];
	assign toClear = ctlWrite & hwdata[`UAB_CTL_TO_CLR];
	// a run is armed only from idle; the counter is zeroed then too
	assign armNow = startWrite && (state_q == ST_IDLE);

	// plain stored fields; scratch touches nothing else
	always @(posedge clk) begin
		if (reset) begin
			scratch_q <= `UAB_SCRATCH_RESET;
			mode_q <= `UAB_CTL_RESET;
			restart_q <= `UAB_CTL_RESET;
			completionEnable_q <= 1'b0;
			timeoutEnable_q <= 1'b0;
		end else if (wrPend_q) begin
			if (hit(wrAddr_q, `UAB_SCRATCH_ADDR)) begin
				scratch_q <= hwdata[7:0];
			end
			if (ctlWrite) begin
				mode_q <= hwdata[`UAB_CTL_MODE];
				restart_q <= hwdata[`UAB_CTL_RESTART];
			end
			if (hit(wrAddr_q, `UAB_ENABLE_ADDR)) begin
				completionEnable_q <= hwdata[`UAB_EV_COMPLETION];
				timeoutEnable_q <= hwdata[`UAB_EV_TIMEOUT];
			end
		end
	end

	// stop edge: fall of first data bit, or rise ending start bit
	assign stopEdge = mode_q ? rxRise : rxFall;

	// a tick on the stop edge belongs to the span, else exact bits read one short
	assign spanCount = rateCount + {{(CNT_WIDTH-1){1'b0}}, prescaleTick};
	// mode 0 spans two bits, so halve; sixteen-cycle ticks give the divisor
	assign loadValue = mode_q ? spanCount : {1'b0, spanCount[CNT_WIDTH-1:1]};
	// pad on purpose, so a narrow counter still fills both latches
	assign loadWide = {16'h0000, loadValue};

	// prescaler tick only while measuring
	assign prescaleTick = (state_q == ST_MEAS) && (prescale_q == `UAB_PRESCALE - 5'h01);

	// next state; an abort write beats every other event
	always @* begin
		state_d = state_q;
		enterMeas = 1'b0;
		measDone = 1'b0;
		measTimeout = 1'b0;
		if (abortWrite) begin
			state_d = ST_IDLE;
		end else if (startWrite && state_q == ST_IDLE) begin
			state_d = ST_WAIT;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_WAIT: begin
					// falling edge opens the start bit
					if (rxFall) begin
						state_d = ST_MEAS;
						enterMeas = 1'b1;
					end
				end
				ST_MEAS: begin
					if (rateOverflow) begin
						// time-out: no load, maybe re-arm
						measTimeout = 1'b1;
						state_d = restart_q ? ST_WAIT : ST_IDLE;
					end else if (stopEdge) begin
						measDone = 1'b1;
						state_d = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// machine, prescaler and shift-register controls
	always @(posedge clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			prescale_q <= 5'h00;
			ticksLeft_q <= 5'h00;
			rsrReset <= 1'b0;
			rsrBaudTick <= 1'b0;
			rsrFastRate <= 1'b0;
		end else begin
			state_q <= state_d;
			// reset receive shift register as a run is armed
			rsrReset <= startWrite && state_q == ST_IDLE;
			// fast rate from arming until the latches load
			rsrFastRate <= (state_d != ST_IDLE);
			if (enterMeas || prescaleTick) begin
				prescale_q <= 5'h00;
			end else if (state_q == ST_MEAS) begin
				prescale_q <= prescale_q + 5'h01;
			end
			// sixteen clock-rate ticks capture the start bit
			if (enterMeas) begin
				ticksLeft_q <= `UAB_RSR_TICKS;
				rsrBaudTick <= 1'b0;
			end else if (state_q == ST_MEAS && ticksLeft_q != 5'h00) begin
				ticksLeft_q <= ticksLeft_q - 5'h01;
				rsrBaudTick <= 1'b1;
			end else begin
				ticksLeft_q <= 5'h00;
				rsrBaudTick <= 1'b0;
			end
		end
	end

	// divisor latches: hardware load beats a software write
	always @(posedge clk) begin
		if (reset) begin
			divisorLowByte <= `UAB_DIVISOR_LOW_RESET;
			divisorHighByte <= `UAB_DIVISOR_HIGH_RESET;
			loadDone_q <= 1'b0;
		end else begin
			loadDone_q <= measDone;
			if (measDone) begin
				{divisorHighByte, divisorLowByte} <= loadWide[15:0];
			end else if (wrPend_q && hit(wrAddr_q, `UAB_DIVISOR_ADDR)) begin
				{divisorHighByte, divisorLowByte} <= hwdata[15:0];
			end
		end
	end

	// event flags: a set in the same cycle as its clear wins
	always @(posedge clk) begin
		if (reset) begin
			completionEventFlag <= 1'b0;
			timeoutEventFlag <= 1'b0;
		end else begin
			// completion only after the latches hold the new value
			if (loadDone_q && completionEnable_q) begin
				completionEventFlag <= 1'b1;
			end else if (eoClear) begin
				completionEventFlag <= 1'b0;
			end
			if (measTimeout && timeoutEnable_q) begin
				timeoutEventFlag <= 1'b1;
			end else if (toClear) begin
				timeoutEventFlag <= 1'b0;
			end
		end
	end

	// hsize is unused: only whole words are carried
	wire unusedSize;
	assign unusedSize = ^hsize;

endmodule // uab_autobaud

`default_nettype wire

// ### verilog/uab_autobaud_regs.vh
// Purpose: addresses, bit positions, reset values and counts of the auto-baud unit
// Assumes: included by the auto-baud top module and the test files by bare name
// Notes: byte addresses on the AHB-Lite bus, one 32-bit word per register
`ifndef UAB_AUTOBAUD_REGS_VH
`define UAB_AUTOBAUD_REGS_VH

// register byte addresses
`define UAB_SCRATCH_ADDR 32'h4000801c
`define UAB_CONTROL_ADDR 32'h40008020
`define UAB_DIVISOR_ADDR 32'h40008040
`define UAB_ENABLE_ADDR 32'h40008044
`define UAB_FLAGS_ADDR 32'h40008048

// control register bit positions
`define UAB_CTL_START 0
`define UAB_CTL_MODE 1
`define UAB_CTL_RESTART 2
`define UAB_CTL_EO_CLR 8
`define UAB_CTL_TO_CLR 9

// enable and flag register bit positions
`define UAB_EV_COMPLETION 0
`define UAB_EV_TIMEOUT 1

// reset values
`define UAB_SCRATCH_RESET 8'h00
`define UAB_DIVISOR_RESET 16'h0001
`define UAB_DIVISOR_LOW_RESET 8'h01
`define UAB_DIVISOR_HIGH_RESET 8'h00
`define UAB_CTL_RESET 1'b0

// timing counts in clock cycles
`define UAB_PRESCALE 5'h10
`define UAB_RSR_TICKS 5'h10

`endif

// ### verilog/uab_rx_sync.v
// Purpose: bring the receive pin into the clock domain and find its edges
// Assumes: rxd is asynchronous to clk
// Notes: edges are seen two cycles after the pin moves
`timescale 1ns/1ps
`default_nettype none

module uab_rx_sync (
	input wire clk,
	input wire reset,
	input wire rxd,
	output wire rxFall,
	output wire rxRise
);
	reg meta_q; // first stage, read only by the second
	reg sync_q; // second stage, safe to use
	reg prev_q; // last safe value, for edge detection

	// idle line is high, so all stages reset high
	always @(posedge clk) begin
		if (reset) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= rxd;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign rxFall = prev_q & ~sync_q; // high to low
	assign rxRise = ~prev_q & sync_q; // low to high
endmodule // uab_rx_sync

`default_nettype wire

// ### verilog/uab_rate_counter.v
// Purpose: measurement counter for the bit time
// Assumes: tick is a one-cycle enable from the prescaler
// Notes: overflow is a pulse in the cycle the counter wraps
`timescale 1ns/1ps
`default_nettype none

module uab_rate_counter #(
	parameter WIDTH = 16
) (
	input wire clk,
	input wire reset,
	input wire clear,
	input wire tick,
	output reg [WIDTH-1:0] count,
	output wire overflow
);
	// clear wins over counting
	always @(posedge clk) begin
		if (reset || clear) begin
			count <= {WIDTH{1'b0}};
		end else if (tick) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign overflow = tick & (&count); // wrap of the full count
endmodule // uab_rate_counter

`default_nettype wire

// ### test/uab_autobaud_asserts.sv
// Purpose: concurrent checks on the auto-baud unit ports
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every instance of uab_autobaud
`timescale 1ns/1ps
`default_nettype none
`include "uab_autobaud_regs.vh"
module uab_autobaud_asserts (
	input wire clk,
	input wire reset,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hwdata,
	input wire [7:0] divisorLowByte,
	input wire [7:0] divisorHighByte,
	input wire rsrReset,
	input wire rsrBaudTick,
	input wire rsrFastRate,
	input wire completionEventFlag,
	input wire timeoutEventFlag
);
	logic [4:0] tickRun_q; // consecutive tick cycles seen
	logic wrPh_q; // a write data phase is under way
	logic [31:0] addr_q; // address of that write
	wire idle = !rsrFastRate; // no run in progress
	wire ctlWr = wrPh_q && addr_q == `UAB_CONTROL_ADDR;
	wire scrWr = wrPh_q && addr_q == `UAB_SCRATCH_ADDR;
	wire divWr = wrPh_q && addr_q == `UAB_DIVISOR_ADDR;
	// helper state tracks the bus and the tick burst
	always_ff @(posedge clk) begin
		if (reset) begin
			tickRun_q <= 5'h00;
			wrPh_q <= 1'b0;
		end else begin
			tickRun_q <= rsrBaudTick ? tickRun_q + 5'h01 : 5'h00;
			wrPh_q <= hsel && htrans[1] && hready && hwrite;
		end
		addr_q <= haddr;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// arming: one-cycle pulse, fast rate on behind it
	sequence sArmed;
		rsrReset ##1 (!rsrReset && rsrFastRate);
	endsequence
	a_arm_pulse: assert property (rsrReset |-> sArmed)
		else $error("arm pulse malformed");
	a_tick_burst: assert property ($fell(rsrBaudTick) |-> tickRun_q == 5'h10)
		else $error("tick burst not sixteen cycles");
	a_eo_after_load: assert property ($rose(completionEventFlag) |->
		$past(rsrFastRate, 2) && !$past(rsrFastRate)) else $error("completion not after load");
	a_div_quiet: assert property ($changed({divisorHighByte, divisorLowByte}) |->
		$past(divWr) || $fell(rsrFastRate)) else $error("divisor moved unasked");
	a_to_noload: assert property ($rose(timeoutEventFlag) |->
		$stable({divisorHighByte, divisorLowByte})) else $error("timeout loaded divisor");
	a_scratch_quiet: assert property ($past(scrWr) && $past(idle, 2) |->
		$stable({completionEventFlag, timeoutEventFlag})) else $error("scratch moved a flag");
	a_clear_eo: assert property (ctlWr && hwdata[8] && idle && $past(idle) |=>
		!completionEventFlag) else $error("completion flag not cleared");
	a_clear_to: assert property (ctlWr && hwdata[9] && idle && $past(idle) |=>
		!timeoutEventFlag) else $error("timeout flag not cleared");
endmodule // uab_autobaud_asserts
bind uab_autobaud uab_autobaud_asserts i_asserts (.clk(clk), .reset(reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.divisorLowByte(divisorLowByte), .divisorHighByte(divisorHighByte),
	.rsrReset(rsrReset), .rsrBaudTick(rsrBaudTick), .rsrFastRate(rsrFastRate),
	.completionEventFlag(completionEventFlag), .timeoutEventFlag(timeoutEventFlag));
`default_nettype wire

// ### test/uab_remote_tx.sv
// Purpose: remote sender of attention characters on the receive pin
// Assumes: bit time given in clock cycles by the caller
// Notes: line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module uab_remote_tx (
	input wire logic clk,
	output logic rxd
);
	initial rxd = 1'b1; // idle level of the line
	// one frame, lsb first; start bit and lsb bounded by two falls
	task automatic sendChar(input logic [7:0] ch, input int bitCyc);
		logic [9:0] frame;
		frame = {1'b1, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= frame[i];
			repeat (bitCyc) @(posedge clk);
		end
	endtask
	// stuck-low line, as a dead or very slow sender gives
	task automatic holdLow(input int cyc);
		rxd <= 1'b0;
		repeat (cyc) @(posedge clk);
		rxd <= 1'b1;
	endtask
endmodule // uab_remote_tx
`default_nettype wire

// ### test/uab_tb_top.sv
// Purpose: self-checking bench for the auto-baud unit
// Assumes: counter narrowed to 8 bits so overflow comes fast
// Notes: the bus master holds each phase until hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "uab_autobaud_regs.vh"
module tb_top;
	localparam logic [31:0] SCR = `UAB_SCRATCH_ADDR;
	localparam logic [31:0] CTL = `UAB_CONTROL_ADDR;
	localparam logic [31:0] DIV = `UAB_DIVISOR_ADDR;
	localparam logic [31:0] FLG = `UAB_FLAGS_ADDR;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	wire hreadyout;
	wire [31:0] hrdata;
	wire rxd;
	wire [7:0] divLo;
	wire [7:0] divHi;
	int badCount = 0;
	int totalChecks = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	uab_autobaud #(.CNT_WIDTH(8)) i_uab_autobaud (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .rxd(rxd),
		.divisorLowByte(divLo), .divisorHighByte(divHi), .rsrReset(), .rsrBaudTick(),
		.rsrFastRate(), .completionEventFlag(), .timeoutEventFlag());
	uab_remote_tx i_uab_remote_tx (.clk(clk), .rxd(rxd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one transfer; address phase then data phase, each until ready
	task automatic busXfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		busXfer(1'b1, a, d, q);
	endtask
	task automatic rdChk(input logic [31:0] a, exp);
		logic [31:0] q;
		busXfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic tRegs;
		rdChk(SCR, 32'h0);
		rdChk(CTL, 32'h0);
		wr(SCR, 32'hffffff5a);
		wr(32'h40008100, 32'h000000c3);
		rdChk(SCR, 32'h5a);
		rdChk(32'h40008100, 32'h0);
		rdChk(FLG, 32'h0);
		$display("test regs done");
	endtask
	// the fractional divider lies outside this block and stays off
	// divisor first, then format and start; expect n from either mode
	task automatic tMeasure(input logic mode, input logic [7:0] ch, input int n);
		wr(DIV, 32'hee);
		wr(CTL, {30'h0, mode, 1'b1});
		rdChk(CTL, {30'h0, mode, 1'b1});
		i_uab_remote_tx.sendChar(ch, 16 * n);
		rdChk(DIV, 32'(n));
		chk({16'h0, divHi, divLo}, 32'(n));
		rdChk(CTL, {30'h0, mode, 1'b0});
		rdChk(FLG, 32'h1);
		wr(SCR, 32'h000000a5);
		rdChk(FLG, 32'h1);
		wr(CTL, {22'h0, 2'b01, 6'h0, mode, 1'b0});
		rdChk(FLG, 32'h0);
		$display("test measure done");
	endtask
	// stuck line overflows the counter; optional re-arm on next fall
	task automatic tTimeout(input logic restart);
		wr(DIV, 32'h7);
		wr(CTL, {29'h0, restart, 2'b11});
		i_uab_remote_tx.holdLow(4400);
		rdChk(FLG, 32'h2);
		rdChk(DIV, 32'h7);
		rdChk(CTL, {29'h0, restart, 1'b1, restart});
		if (restart) begin
			i_uab_remote_tx.sendChar(8'h61, 64);
			rdChk(DIV, 32'h4);
		end
		wr(CTL, 32'h300);
		rdChk(FLG, 32'h0);
		$display("test timeout done");
	endtask
	task automatic tAbort;
		wr(DIV, 32'h9);
		wr(CTL, 32'h1);
		fork
			i_uab_remote_tx.sendChar(8'h41, 96);
			begin
				repeat (40) @(posedge clk);
				wr(CTL, 32'h0);
			end
		join
		rdChk(CTL, 32'h0);
		rdChk(DIV, 32'h9);
		rdChk(FLG, 32'h0);
		$display("test abort done");
	endtask
	task automatic completeRun;
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard, well above the roughly twelve thousand cycles of a run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			badCount++;
			completeRun;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		tRegs;
		wr(32'h40008044, 32'h3);
		tMeasure(1'b0, 8'h41, 3);
		tMeasure(1'b1, 8'h61, 5);
		tTimeout(1'b0);
		tTimeout(1'b1);
		tAbort;
		completeRun;
	end
endmodule // tb_top
`default_nettype wire
